// ==== hw/ntbbar_regs.sv ====
// Window base registers and self-test byte of a bridge configuration header.
// Assumes one AHB-Lite master, hready tied to hreadyout, core_clk at 100 MHz.
//
// Overview of operation
// - Self-test byte is read-only and always reads zero.
// - Bit 0 of each base register except paired base 1 mirrors its setup space indicator.
// - Space indicator zero selects memory space, one selects I/O space.
// - Base 0 bits 2:1 mirror setup address types 0 and 2 in memory space; types 1 and 3 read zero.
// - Address type 0 is 32-bit, 2 is 64-bit; 1 and 3 reserved.
// - In I/O space, address type and prefetch bits read zero.
// - Base 0 bit 3 mirrors setup prefetch setting in memory space.
// - Prefetch bit zero is non-prefetchable, one is prefetchable.
// - Bits 31:4 reset to zero, are writable and feed transaction decode.
// - Only bits the setup size allows take writes, except in paired base 1; others read zero.
// - Base 0 in 64-bit memory mode makes base 1 its upper half.
// - A standalone odd base register only reports 32-bit address type.
`timescale 1ns/1ps
`include "ntbbar_map.svh"

module ntbbar_regs
	import ntbbar_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output ntbbar_decode_t   windowDecode
);

	// Index of the base register of window n
	function automatic logic [7:0] baseIndex(input int n);
		case (n)
			0:       return `NTBBAR_IDX_BASE0;
			1:       return `NTBBAR_IDX_BASE1;
			default: return `NTBBAR_IDX_BASE2;
		endcase
	endfunction : baseIndex

	function automatic logic [7:0] setupIndex(input int n);
		case (n)
			0:       return `NTBBAR_IDX_SETUP0;
			1:       return `NTBBAR_IDX_SETUP1;
			default: return `NTBBAR_IDX_SETUP2;
		endcase
	endfunction : setupIndex

	// Address bits 31:4 at or above the window size are writable
	function automatic logic [27:0] writeMask(input logic [4:0] sizeLog2);
		logic [27:0] m;
		m = '0;
		for (int k = 0; k < 28; k++) begin
			m[k] = ((k + `NTBBAR_BASE_ADDR_BITS_LSB) >= int'(sizeLog2));
		end
		return m;
	endfunction : writeMask

	// Read-only attribute nibble of a base register
	function automatic logic [3:0] attrBits(input ntbbar_setup_t s, input logic oddBar);
		logic [1:0] t;
		t = `NTBBAR_TYPE_ADDR32;
		if (s.spaceIndicator == `NTBBAR_SPACE_IO) begin
			return {3'h0, `NTBBAR_SPACE_IO};
		end
		// Reserved codes and odd windows fall back to 32-bit
		if (!oddBar && s.addrType == `NTBBAR_TYPE_ADDR64) begin
			t = `NTBBAR_TYPE_ADDR64;
		end
		return {s.prefetchableFlag, t, `NTBBAR_SPACE_MEM};
	endfunction : attrBits

	ntbbar_phase_t  phase_reg;
	ntbbar_phase_t  phase_next;
	ntbbar_req_t    req_reg;
	ntbbar_setup_t  windowSetup_reg [3];
	logic [27:0]    baseBits_reg [3];
	logic [3:0]     upperLow_reg;
	logic [31:0]    hrdata_reg;
	ntbbar_decode_t windowDecode_reg;
	logic [27:0]    winMask [3];
	logic [31:0]    barView [3];
	logic [31:0]    readValue;
	logic           addrAccept;
	logic           wrStrobe;
	logic           pairMode;
	logic [7:0]     reqIndexIn;
	logic           reqMapped;

	// Bus phase tracking

	assign addrAccept = hsel && hready && htrans[1];
	assign reqIndexIn = haddr[9:2];
	assign reqMapped  = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
	assign wrStrobe   = (phase_reg == PH_WRITE) && req_reg.write && req_reg.word && req_reg.mapped;

	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			PH_READ_WAIT: begin
				phase_next = PH_READ_DONE;
			end
			default: begin
				if (addrAccept) begin
					phase_next = hwrite ? PH_WRITE : PH_READ_WAIT;
				end else begin
					phase_next = PH_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			phase_reg <= PH_IDLE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			req_reg <= '0;
		end else if (addrAccept) begin
			req_reg <= '{write: hwrite, word: (hsize == `NTBBAR_HSIZE_WORD),
				mapped: reqMapped, index: reqIndexIn};
		end
	end

	// One wait state on reads so a write just before is visible
	assign hreadyout = (phase_reg != PH_READ_WAIT);
	assign hresp     = `NTBBAR_HRESP_OKAY;
	assign hrdata    = hrdata_reg;

	// Windows

	assign pairMode = (windowSetup_reg[0].spaceIndicator == `NTBBAR_SPACE_MEM) &&
		(windowSetup_reg[0].addrType == `NTBBAR_TYPE_ADDR64);

	genvar gi;
	for (gi = 0; gi < 3; gi++) begin : g_win
		if (gi == 1) begin : g_odd
			// Paired upper half takes every bit
			assign winMask[gi] = pairMode ? '1 : writeMask(windowSetup_reg[gi].sizeLog2);
			assign barView[gi] = pairMode ? {baseBits_reg[gi], upperLow_reg} :
				{baseBits_reg[gi] & winMask[gi], attrBits(windowSetup_reg[gi], 1'b1)};
		end else begin : g_even
			assign winMask[gi] = writeMask(windowSetup_reg[gi].sizeLog2);
			assign barView[gi] = {baseBits_reg[gi] & winMask[gi],
				attrBits(windowSetup_reg[gi], 1'b0)};
		end

		always_ff @(posedge core_clk) begin
			if (reset) begin
				baseBits_reg[gi] <= `NTBBAR_BASE_RST;
			end else if (wrStrobe && req_reg.index == baseIndex(gi)) begin
				// Bits 3:0 of hwdata dropped here
				baseBits_reg[gi] <= hwdata[31:4] & winMask[gi];
			end
		end

		always_ff @(posedge core_clk) begin
			if (reset) begin
				windowSetup_reg[gi] <= ntbbar_setup_t'(`NTBBAR_SETUP_RST);
			end else if (wrStrobe && req_reg.index == setupIndex(gi)) begin
				windowSetup_reg[gi] <= ntbbar_setup_t'(hwdata[`NTBBAR_SETUP_MSB:0]);
			end
		end
	end

	// Address bits 35:32 live here only while paired
	always_ff @(posedge core_clk) begin
		if (reset) begin
			upperLow_reg <= 4'h0;
		end else if (wrStrobe && pairMode && req_reg.index == `NTBBAR_IDX_BASE1) begin
			upperLow_reg <= hwdata[3:0];
		end
	end

	// Read path

	always_comb begin
		readValue = 32'h00000000;
		if (!req_reg.mapped) begin
			readValue = 32'h00000000;
		end else if (req_reg.index == `NTBBAR_IDX_SELFTEST) begin
			readValue = {24'h000000, `NTBBAR_SELFTEST_VAL};
		end else if (req_reg.index == `NTBBAR_IDX_BASE0) begin
			readValue = barView[0];
		end else if (req_reg.index == `NTBBAR_IDX_BASE1) begin
			readValue = barView[1];
		end else if (req_reg.index == `NTBBAR_IDX_BASE2) begin
			readValue = barView[2];
		end else if (req_reg.index == `NTBBAR_IDX_SETUP0) begin
			readValue = {23'h000000, windowSetup_reg[0]};
		end else if (req_reg.index == `NTBBAR_IDX_SETUP1) begin
			readValue = {23'h000000, windowSetup_reg[1]};
		end else if (req_reg.index == `NTBBAR_IDX_SETUP2) begin
			readValue = {23'h000000, windowSetup_reg[2]};
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			hrdata_reg <= 32'h00000000;
		end else if (phase_reg == PH_READ_WAIT) begin
			hrdata_reg <= readValue;
		end
	end

	// Decode addresses, low attribute bits cleared

	always_ff @(posedge core_clk) begin
		if (reset) begin
			windowDecode_reg <= '0;
		end else begin
			windowDecode_reg.base0 <= {pairMode ? barView[1] : 32'h00000000,
				barView[0][31:4], 4'h0};
			windowDecode_reg.base1 <= pairMode ? 32'h00000000 : {barView[1][31:4], 4'h0};
			windowDecode_reg.base2 <= {barView[2][31:4], 4'h0};
			windowDecode_reg.pairMode <= pairMode;
		end
	end

	assign windowDecode = windowDecode_reg;

	// Checks

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	a_selftest_zero: assert property (
		(phase_reg == PH_READ_WAIT && req_reg.mapped && req_reg.index == `NTBBAR_IDX_SELFTEST)
		|=> (hrdata == 32'h00000000) && hreadyout)
		else $error("self-test byte read nonzero");

	a_space_mirror: assert property (
		(phase_reg == PH_READ_WAIT && req_reg.mapped && req_reg.index == `NTBBAR_IDX_BASE0)
		|=> hrdata[`NTBBAR_SPACE_BIT] == $past(windowSetup_reg[0].spaceIndicator))
		else $error("base 0 space bit does not follow setup");

	a_io_space_one: assert property (
		(windowSetup_reg[2].spaceIndicator == `NTBBAR_SPACE_IO)
		|-> barView[2][`NTBBAR_SPACE_BIT] == 1'b1)
		else $error("io window does not show space bit set");

	a_type_mirror: assert property (
		(phase_reg == PH_READ_WAIT && req_reg.mapped && req_reg.index == `NTBBAR_IDX_BASE0 &&
		 pairMode)
		|=> hrdata[`NTBBAR_TYPE_MSB:`NTBBAR_TYPE_LSB] == `NTBBAR_TYPE_ADDR64)
		else $error("base 0 type not 64-bit in paired mode");

	a_type_legal: assert property (
		barView[0][2:1] != 2'h1 && barView[0][2:1] != 2'h3)
		else $error("base 0 shows a reserved address type");

	a_io_attr_zero: assert property (
		(windowSetup_reg[0].spaceIndicator == `NTBBAR_SPACE_IO) |-> barView[0][3:1] == 3'h0)
		else $error("io window shows type or prefetch");

	a_prefetchable_flag_mirror: assert property (
		(phase_reg == PH_READ_WAIT && req_reg.index == `NTBBAR_IDX_BASE0 && req_reg.mapped &&
		 windowSetup_reg[0].spaceIndicator == `NTBBAR_SPACE_MEM)
		|=> hrdata[`NTBBAR_PREFETCHABLE_FLAG_BIT] == $past(windowSetup_reg[0].prefetchableFlag))
		else $error("base 0 prefetch bit does not follow setup");

	a_base_reset: assert property (
		$past(reset) |-> baseBits_reg[0] == 28'h0 && baseBits_reg[1] == 28'h0 &&
		baseBits_reg[2] == 28'h0)
		else $error("base bits not zero after reset");

	a_write_lands: assert property (
		(wrStrobe && req_reg.index == `NTBBAR_IDX_BASE2)
		|=> barView[2][31:4] == ($past(hwdata[31:4]) & winMask[2]))
		else $error("base 2 write did not land");

	a_size_mask: assert property (
		(barView[0][31:4] & ~writeMask(windowSetup_reg[0].sizeLog2)) == 28'h0)
		else $error("base 0 shows bits below window size");

	a_pair_upper: assert property (
		pairMode |=> windowDecode.base0[63:32] == $past(barView[1]) && windowDecode.pairMode)
		else $error("paired upper half not in decode");

	a_odd_type: assert property (
		!pairMode |-> barView[1][2:1] == `NTBBAR_TYPE_ADDR32)
		else $error("standalone odd window shows 64-bit type");

	a_attr_kept: assert property (
		(wrStrobe && req_reg.index == `NTBBAR_IDX_BASE0)
		|=> barView[0][3:0] == $past(barView[0][3:0]))
		else $error("write altered base 0 attribute bits");

	a_read_wait: assert property (
		(addrAccept && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state not one cycle");

	a_resp_okay: assert property (
		hresp == `NTBBAR_HRESP_OKAY)
		else $error("bus response not okay");

	// Narrow writes would otherwise tear a base address in half
	a_narrow_drop: assert property (
		(phase_reg == PH_WRITE && !req_reg.word)
		|=> baseBits_reg[2] == $past(baseBits_reg[2]) &&
		baseBits_reg[0] == $past(baseBits_reg[0]))
		else $error("sub-word write changed a base register");

	a_io2_attr_zero: assert property (
		(windowSetup_reg[2].spaceIndicator == `NTBBAR_SPACE_IO) |-> barView[2][3:1] == 3'h0)
		else $error("io window 2 shows type or prefetch");

	a_decode_clean: assert property (
		windowDecode.base0[3:0] == 4'h0 && windowDecode.base1[3:0] == 4'h0 &&
		windowDecode.base2[3:0] == 4'h0)
		else $error("decode address carries attribute bits");

	a_masked_store: assert property (
		(wrStrobe && req_reg.index == `NTBBAR_IDX_BASE2)
		|=> (baseBits_reg[2] & ~winMask[2]) == 28'h0)
		else $error("base 2 stored bits below window size");

	a_upper_write: assert property (
		(wrStrobe && pairMode && req_reg.index == `NTBBAR_IDX_BASE1)
		|=> barView[1] == $past(hwdata))
		else $error("paired upper half did not take all bits");

	a_unpaired_upper: assert property (
		!pairMode |=> windowDecode.base0[63:32] == 32'h00000000 && !windowDecode.pairMode)
		else $error("unpaired window 0 shows an upper half");

	// Read data must stand until the next read loads it
	a_rdata_hold: assert property (
		(phase_reg != PH_READ_WAIT) |=> $stable(hrdata))
		else $error("read data changed outside a read");

endmodule : ntbbar_regs

// ==== hw/ntbbar_map.svh ====
// Offsets, field positions, reset values and bus codes of the window base registers.
// Assumes a 32-bit AHB-Lite slave; byte address of a register is four times its index.
`ifndef NTBBAR_MAP_SVH
`define NTBBAR_MAP_SVH

// Register indices; byte address = index * 4
`define NTBBAR_IDX_SELFTEST  8'h0f
`define NTBBAR_IDX_BASE0     8'h10
`define NTBBAR_IDX_BASE1     8'h14
`define NTBBAR_IDX_BASE2     8'h18
`define NTBBAR_IDX_SETUP0    8'h20
`define NTBBAR_IDX_SETUP1    8'h21
`define NTBBAR_IDX_SETUP2    8'h22

// Field positions inside a window base register
`define NTBBAR_SPACE_BIT     0
`define NTBBAR_TYPE_MSB      2
`define NTBBAR_TYPE_LSB      1
`define NTBBAR_PREFETCHABLE_FLAG_BIT      3
`define NTBBAR_BASE_ADDR_BITS_LSB     4
`define NTBBAR_SETUP_MSB     8

// Encodings
`define NTBBAR_SPACE_MEM     1'b0
`define NTBBAR_SPACE_IO      1'b1
`define NTBBAR_TYPE_ADDR32   2'h0
`define NTBBAR_TYPE_ADDR64   2'h2
`define NTBBAR_PREFETCHABLE_FLAG_OFF      1'b0
`define NTBBAR_PREFETCHABLE_FLAG_ON       1'b1

// Reset and fixed values
`define NTBBAR_SELFTEST_VAL  8'h00
`define NTBBAR_BASE_RST      28'h0000000
`define NTBBAR_SETUP_RST     9'h0c0

// AHB-Lite codes
`define NTBBAR_HSIZE_WORD    3'h2
`define NTBBAR_HRESP_OKAY    1'b0

`endif

// ==== hw/ntbbar_pkg.sv ====
// Types shared by the window base register bank.
// Assumes ntbbar_map.svh for all numeric constants.
package ntbbar_pkg;

	// Internal setup of one window, laid out as its register
	typedef struct packed {
		logic [4:0] sizeLog2;
		logic       prefetchableFlag;
		logic [1:0] addrType;
		logic       spaceIndicator;
	} ntbbar_setup_t;

	// Captured AHB address phase
	typedef struct packed {
		logic       write;
		logic       word;
		logic       mapped;
		logic [7:0] index;
	} ntbbar_req_t;

	// Decode addresses handed to the transaction path
	typedef struct packed {
		logic [63:0] base0;
		logic [31:0] base1;
		logic [31:0] base2;
		logic        pairMode;
	} ntbbar_decode_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WRITE,
		PH_READ_WAIT,
		PH_READ_DONE
	} ntbbar_phase_t;

endpackage : ntbbar_pkg

// ==== dv/ntbbar_host_model.sv ====
// AHB-Lite master standing in for configuration software.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module ntbbar_host_model (
	input  wire logic        core_clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h5a5a5a5a;
	end

	// Called just after a rising edge; waits on hready with no fixed latency
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [2:0] sz,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~haddr;
		hwdata <= w ? d : ~hwdata;
		do @(posedge core_clk); while (hready !== 1'b1);
		q = hrdata;
		// Released data lines must not keep their last value
		hwdata <= ~hwdata;
	endtask : xfer
endmodule : ntbbar_host_model

// ==== dv/ntbbar_regs_test.sv ====
// Self-checking bench for the window base register bank.
// Assumes ntbbar_host_model drives the bus; hready is the slave's hreadyout.
`timescale 1ns/1ps
`include "ntbbar_map.svh"
module ntbbar_regs_test
	import ntbbar_pkg::*;
;
	logic           core_clk;
	logic           reset;
	logic           hsel;
	logic [31:0]    haddr;
	logic [1:0]     htrans;
	logic           hwrite;
	logic [2:0]     hsize;
	logic [31:0]    hwdata;
	logic           hreadyout;
	logic           hresp;
	logic [31:0]    hrdata;
	logic [31:0]    q;
	ntbbar_decode_t windowDecode;
	int             errTotal = 0;
	int             nChecks = 0;
	int             cycles = 0;

	ntbbar_regs dut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.windowDecode(windowDecode));

	ntbbar_host_model host (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));

	task automatic testDone();
		$display("checks %0d errors %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : testDone

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		nChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] r;
		host.xfer(1'b1, idx, `NTBBAR_HSIZE_WORD, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
		logic [31:0] r;
		host.xfer(1'b0, idx, `NTBBAR_HSIZE_WORD, 32'h0, r);
		chk(nm, {32'h0, r}, {32'h0, exp});
	endtask : rd

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Hang guard; the full sequence needs about a hundred cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errTotal++;
			testDone();
		end
	end

	initial begin
		reset = 1'b1;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		rd(`NTBBAR_IDX_SELFTEST, 32'h0, "selftest");
		wr(`NTBBAR_IDX_SELFTEST, 32'hffffffff);
		rd(`NTBBAR_IDX_SELFTEST, 32'h0, "selftest");
		rd(`NTBBAR_IDX_BASE0, 32'h0, "base0");
		wr(`NTBBAR_IDX_BASE0, 32'hffffffff);
		for (int t = 0; t < 4; t++) begin
			wr(`NTBBAR_IDX_SETUP0, {23'h0, 5'hc, 1'b1, t[1:0], 1'b0});
			rd(`NTBBAR_IDX_BASE0, {28'hfffff00, 1'b1, (t == 2) ? 2'h2 : 2'h0, 1'b0}, "base0");
		end
		wr(`NTBBAR_IDX_SETUP0, 32'h0cc);
		// Setup0 now memory, 64-bit: base 1 is the upper half
		wr(`NTBBAR_IDX_BASE1, 32'hdeadbeef);
		rd(`NTBBAR_IDX_BASE1, 32'hdeadbeef, "base1");
		chk("dec0", windowDecode.base0, 64'hdeadbeef_fffff000);
		chk("pair", {63'h0, windowDecode.pairMode}, 64'h1);
		chk("dec1", {32'h0, windowDecode.base1}, 64'h0);
		wr(`NTBBAR_IDX_SETUP0, 32'h0cd);
		rd(`NTBBAR_IDX_BASE0, 32'hfffff001, "base0");
		chk("pair", {63'h0, windowDecode.pairMode}, 64'h0);
		wr(`NTBBAR_IDX_SETUP1, 32'h0cc);
		wr(`NTBBAR_IDX_BASE1, 32'hffffffff);
		rd(`NTBBAR_IDX_BASE1, 32'hfffff008, "base1");
		chk("dec1", {32'h0, windowDecode.base1}, 64'hfffff000);
		wr(`NTBBAR_IDX_SETUP2, 32'h140);
		wr(`NTBBAR_IDX_BASE2, 32'hffffffff);
		rd(`NTBBAR_IDX_BASE2, 32'hfff00000, "base2");
		wr(`NTBBAR_IDX_SETUP2, 32'h001);
		wr(`NTBBAR_IDX_BASE2, 32'h12345678);
		rd(`NTBBAR_IDX_BASE2, 32'h12345671, "base2");
		chk("dec2", {32'h0, windowDecode.base2}, 64'h12345670);
		// Sub-word write must leave the register alone
		host.xfer(1'b1, `NTBBAR_IDX_BASE2, 3'h0, 32'h0, q);
		rd(`NTBBAR_IDX_BASE2, 32'h12345671, "base2");
		wr(8'h30, 32'hffffffff);
		rd(8'h30, 32'h0, "unmapped");
		chk("hresp", {63'h0, hresp}, 64'h0);
		reset <= 1'b1;
		@(posedge core_clk);
		reset <= 1'b0;
		rd(`NTBBAR_IDX_BASE0, 32'h0, "base0");
		rd(`NTBBAR_IDX_BASE2, 32'h0, "base2");
		testDone();
	end
endmodule : ntbbar_regs_test
